// [rtl/ccdlc_map.vh]
`ifndef CCDLC_MAP_VH
`define CCDLC_MAP_VH

// ****************************************
// Clock and unit bases
// ****************************************
`define CCDLC_CLK_PS 32'h0000_1388
`define CCDLC_CLK_NS 32'h0000_0005
`define CCDLC_NS_PER_S 32'h3B9A_CA00
`define CCDLC_PS_PER_MS 32'h3B9A_CA00

// ****************************************
// Sensor timing figures
// ****************************************
// Transfer gate width, typical 1000 ns (least 800 ns)
`define CCDLC_TG_WIDTH_PS 32'h000F_4240
// Transfer gate to first shift phase overlap, typical 200 ns (least 100 ns)
`define CCDLC_OVR_PS 32'h0003_0D40
// Reset gate width, typical 6 ns (least 5 ns)
`define CCDLC_RG_WIDTH_PS 32'h0000_1770
// Per-port pixel rate, 20 MHz typical, given in kHz
`define CCDLC_PIX_RATE_KHZ 32'h0000_4E20
// Line repeat rate, 36 kHz typical, given in Hz
`define CCDLC_LINE_RATE_HZ 32'h0000_8CA0
`define CCDLC_TOTAL_PIX 32'h0000_0838
`define CCDLC_PORTS 32'h0000_0004

// ****************************************
// Derived cycle counts
// ****************************************
`define CCDLC_CEIL_CYC(t) (((t) + `CCDLC_CLK_PS - 32'h0000_0001) / `CCDLC_CLK_PS)
`define CCDLC_TG_CYC `CCDLC_CEIL_CYC(`CCDLC_TG_WIDTH_PS)
`define CCDLC_OVR_CYC `CCDLC_CEIL_CYC(`CCDLC_OVR_PS)
`define CCDLC_RG_CYC `CCDLC_CEIL_CYC(`CCDLC_RG_WIDTH_PS)
`define CCDLC_PIX_CYC ((`CCDLC_PS_PER_MS / `CCDLC_PIX_RATE_KHZ) / `CCDLC_CLK_PS)
`define CCDLC_LINE_CYC ((`CCDLC_NS_PER_S / `CCDLC_LINE_RATE_HZ) / `CCDLC_CLK_NS)
`define CCDLC_SHIFTS (`CCDLC_TOTAL_PIX / `CCDLC_PORTS)

`endif

// [rtl/ccdlc_sequencer.v]
`timescale 1ns/100ps
`include "ccdlc_map.vh"

module ccdlc_sequencer #(
  parameter TG_CYC = `CCDLC_TG_CYC,
  parameter OVR_CYC = `CCDLC_OVR_CYC,
  parameter RG_CYC = `CCDLC_RG_CYC,
  parameter PIX_CYC = `CCDLC_PIX_CYC,
  parameter LINE_CYC = `CCDLC_LINE_CYC,
  parameter SHIFTS = `CCDLC_SHIFTS,
  parameter CW = 16,
  parameter DW = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  output reg transfer_gate_pulse,
  output reg horiz_shift_clock_one,
  output reg horiz_shift_clock_two,
  output reg reset_gate_pulse,
  output reg line_start,
  output wire pix_valid,
  input wire pix_ready,
  output wire [DW-1:0] pix_index
);

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] S_LEAD = 5'h01;
  localparam [4:0] S_TGHI = 5'h02;
  localparam [4:0] S_TRAIL = 5'h04;
  localparam [4:0] S_READ = 5'h08;
  localparam [4:0] S_DUMMY = 5'h10;

  // Full-width copies first; each is cut to its counter width on purpose below
  localparam [31:0] W_TG = TG_CYC;
  localparam [31:0] W_OVR = OVR_CYC;
  localparam [31:0] W_RG = RG_CYC;
  localparam [31:0] W_PIX = PIX_CYC;
  localparam [31:0] W_HALF = PIX_CYC / 2;
  localparam [31:0] W_LINE = LINE_CYC;
  localparam [31:0] W_LAST = LINE_CYC - PIX_CYC;
  localparam [31:0] W_SHIFTS = SHIFTS;

  localparam [CW-1:0] C_TG = W_TG[CW-1:0];
  localparam [CW-1:0] C_OVR = W_OVR[CW-1:0];
  localparam [CW-1:0] C_RG = W_RG[CW-1:0];
  localparam [CW-1:0] C_PIX = W_PIX[CW-1:0];
  localparam [CW-1:0] C_HALF = W_HALF[CW-1:0];
  localparam [CW-1:0] C_LINE = W_LINE[CW-1:0];
  localparam [CW-1:0] C_LAST_START = W_LAST[CW-1:0];
  localparam [DW-1:0] C_SHIFTS = W_SHIFTS[DW-1:0];
  localparam [CW-1:0] C_ONE = {{(CW-1){1'b0}}, 1'b1};
  localparam [DW-1:0] C_ONE_D = {{(DW-1){1'b0}}, 1'b1};

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg [CW-1:0] ph_r;
  reg [CW-1:0] ph_nxt;
  reg [CW-1:0] line_r;
  reg [DW-1:0] shift_r;
  reg [DW-1:0] shift_nxt;

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  reg [DW-1:0] buf_mem [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] fill_r;
  wire buf_full = fill_r[1];
  wire buf_empty = (fill_r == 2'h0);
  wire pop = pix_valid & pix_ready;
  reg push;

  assign pix_valid = ~buf_empty;
  assign pix_index = buf_mem[rp_r];

  function is_last_phase;
    input [CW-1:0] ph;
    begin
      is_last_phase = (ph == C_PIX - C_ONE);
    end
  endfunction

  // ****************************************
  // Sequence control
  // ****************************************
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + C_ONE;
    ph_nxt = ph_r;
    shift_nxt = shift_r;
    push = 1'b0;
    case (state_r)
      S_LEAD: begin
        if (cnt_r == C_OVR - C_ONE) begin
          state_nxt = S_TGHI;
          cnt_nxt = {CW{1'b0}};
        end
      end
      S_TGHI: begin
        if (cnt_r == C_TG - C_ONE) begin
          state_nxt = S_TRAIL;
          cnt_nxt = {CW{1'b0}};
        end
      end
      S_TRAIL: begin
        if (cnt_r == C_OVR - C_ONE) begin
          state_nxt = S_READ;
          ph_nxt = {CW{1'b0}};
          shift_nxt = {DW{1'b0}};
        end
      end
      S_READ: begin
        if (is_last_phase(ph_r)) begin
          // A full buffer holds phase two high; the line stretches instead of dropping a word
          if (!buf_full) begin
            push = 1'b1;
            ph_nxt = {CW{1'b0}};
            shift_nxt = shift_r + C_ONE_D;
            if (shift_r == C_SHIFTS - C_ONE_D) begin
              if (line_r >= C_LAST_START) begin
                state_nxt = S_LEAD;
              end else begin
                state_nxt = S_DUMMY;
              end
            end
          end
        end else begin
          ph_nxt = ph_r + C_ONE;
        end
      end
      S_DUMMY: begin
        if (is_last_phase(ph_r)) begin
          ph_nxt = {CW{1'b0}};
          if (line_r >= C_LAST_START) begin
            state_nxt = S_LEAD;
          end
        end else begin
          ph_nxt = ph_r + C_ONE;
        end
      end
      default: begin
        state_nxt = S_LEAD;
      end
    endcase
    if (state_nxt == S_LEAD && state_r != S_LEAD) begin
      cnt_nxt = {CW{1'b0}};
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= S_LEAD;
      cnt_r <= {CW{1'b0}};
      ph_r <= {CW{1'b0}};
      line_r <= {CW{1'b0}};
      shift_r <= {DW{1'b0}};
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      shift_r <= shift_nxt;
      if (state_nxt == S_LEAD && state_r != S_LEAD) begin
        line_r <= {CW{1'b0}};
      end else if (line_r != C_LINE) begin
        line_r <= line_r + C_ONE;
      end
    end
  end

  // ****************************************
  // Buffer pointers
  // ****************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      fill_r <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        buf_mem[wp_r] <= shift_r;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Pins lag the state by one cycle so every gate leaves a flop, not a decoder
  wire phase_one = (state_r == S_LEAD) | (state_r == S_TGHI) | (state_r == S_TRAIL) |
                   (ph_r < C_HALF);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      transfer_gate_pulse <= 1'b0;
      horiz_shift_clock_one <= 1'b0;
      horiz_shift_clock_two <= 1'b1;
      reset_gate_pulse <= 1'b0;
      line_start <= 1'b0;
    end else if (clk_en) begin
      transfer_gate_pulse <= (state_r == S_TGHI);
      horiz_shift_clock_one <= phase_one;
      horiz_shift_clock_two <= ~phase_one;
      reset_gate_pulse <= ((state_r == S_READ) | (state_r == S_DUMMY)) & (ph_r < C_RG);
      line_start <= (state_r == S_TGHI) & (cnt_r == {CW{1'b0}});
    end
  end

endmodule // ccdlc_sequencer

// [verification/ccdlc_sequencer_asserts.sv]
`timescale 1ns/100ps
module ccdlc_sequencer_asserts #(
  parameter int TG_CYC = 4,
  parameter int OVR_CYC = 3,
  parameter int PIX_CYC = 10,
  parameter int SHIFTS = 4
) (
  input logic ref_clk,
  input logic rst_n,
  input logic clk_en,
  input logic transfer_gate_pulse,
  input logic horiz_shift_clock_one,
  input logic horiz_shift_clock_two,
  input logic reset_gate_pulse,
  input logic pix_valid,
  input logic pix_ready,
  input logic [11:0] pix_index
);
  localparam int HALF = PIX_CYC / 2;
  logic [7:0] gate_n_r;
  logic [7:0] run_r;
  logic ph_q_r;
  default clocking @(posedge ref_clk);
  endclocking
  // A frozen sequencer stretches every pin, so checks pause while the enable is low
  default disable iff (!rst_n || !clk_en);
  // Run length starts saturated so the first change after reset cannot fire
  always @(posedge ref_clk) begin
    ph_q_r <= horiz_shift_clock_one;
    if (!rst_n) begin
      gate_n_r <= 8'h00;
      run_r <= 8'hFF;
    end else if (clk_en) begin
      gate_n_r <= transfer_gate_pulse ? gate_n_r + 8'h01 : 8'h00;
      run_r <= (horiz_shift_clock_one != ph_q_r) ? 8'h01 : run_r + {7'h00, run_r != 8'hFF};
    end
  end
  // ********
  // Properties
  // ********
  property p_gw; $fell(transfer_gate_pulse) |-> gate_n_r == TG_CYC; endproperty
  a_gw: assert property (p_gw) else $error("gate width");
  property p_lead; $rose(transfer_gate_pulse) |-> $past(horiz_shift_clock_one, OVR_CYC); endproperty
  a_lead: assert property (p_lead) else $error("lead overlap");
  property p_trail; $fell(transfer_gate_pulse) |-> ##OVR_CYC $rose(reset_gate_pulse); endproperty
  a_trail: assert property (p_trail) else $error("trail overlap");
  property p_ph; $changed(horiz_shift_clock_one) |-> run_r >= HALF; endproperty
  a_ph: assert property (p_ph) else $error("phase width");
  property p_rgw; $rose(reset_gate_pulse) |=> reset_gate_pulse ##1 !reset_gate_pulse; endproperty
  a_rgw: assert property (p_rgw) else $error("reset width");
  property p_rgp; $rose(reset_gate_pulse) |-> horiz_shift_clock_one && !transfer_gate_pulse; endproperty
  a_rgp: assert property (p_rgp) else $error("reset place");
  property p_cmp; horiz_shift_clock_two != horiz_shift_clock_one; endproperty
  a_cmp: assert property (p_cmp) else $error("phases");
  property p_hold; pix_valid && !pix_ready |=> pix_valid && $stable(pix_index); endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  c_stall: cover property (pix_valid && !pix_ready ##1 pix_valid);
  c_gate: cover property ($rose(transfer_gate_pulse));
  c_rg: cover property ($rose(reset_gate_pulse));
endmodule // ccdlc_sequencer_asserts

// [verification/ccdlc_ccd_model.sv]
`timescale 1ns/100ps
module ccdlc_ccd_model (
  input logic ref_clk,
  input logic transfer_gate_pulse,
  input logic horiz_shift_clock_one,
  output logic [11:0] shift_cnt_r
);
  logic ph_q_r;
  // Stages moved since the last transfer, dummy ones included
  always @(posedge ref_clk) begin
    ph_q_r <= horiz_shift_clock_one;
    if (transfer_gate_pulse) begin
      shift_cnt_r <= 12'h000;
    end else if (horiz_shift_clock_one && !ph_q_r) begin
      shift_cnt_r <= shift_cnt_r + 12'h001;
    end
  end
endmodule // ccdlc_ccd_model

// [verification/ccdlc_sequencer_tb_top.sv]
`timescale 1ns/100ps
module ccdlc_sequencer_tb_top;
  localparam int SH = 4;
  localparam int LC = 120;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic pix_ready = 1'b0;
  logic transfer_gate_pulse, horiz_shift_clock_one, horiz_shift_clock_two;
  logic reset_gate_pulse, line_start, pix_valid;
  logic [11:0] pix_index, shift_cnt_r;
  int seed = 14806, n_fail = 0, checks = 0, lines = 0, idx = 0, cyc = 0, last = 0, goal = 0;
  logic [3:0] pins4, snap;
  assign pins4 = {transfer_gate_pulse, horiz_shift_clock_one, reset_gate_pulse, pix_valid};
  bit free = 1'b1;
  ccdlc_sequencer #(.TG_CYC(4), .OVR_CYC(3), .PIX_CYC(10), .SHIFTS(SH), .LINE_CYC(LC)) uut (
    .ref_clk, .rst_n, .clk_en, .transfer_gate_pulse, .horiz_shift_clock_one,
    .horiz_shift_clock_two, .reset_gate_pulse, .line_start, .pix_valid, .pix_ready, .pix_index);
  ccdlc_ccd_model sensor (.ref_clk, .transfer_gate_pulse, .horiz_shift_clock_one, .shift_cnt_r);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("fails=%0d checks=%0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    print_verdict;
  end
  // ********
  // Monitors see the values settled in the cycle just ended
  // ********
  always @(posedge ref_clk) begin
    cyc++;
    if (rst_n && clk_en && pix_valid && pix_ready) begin
      chk(16'(pix_index), 16'(idx));
      idx = (idx + 1) % SH;
    end
    if (rst_n && clk_en && line_start) begin
      if (lines > 0 && free) begin
        chk(16'(shift_cnt_r > SH), 16'h0001);
        chk(16'(cyc - last > LC - 10 && cyc - last <= LC + 10), 16'h0001);
      end
      lines++;
      last = cyc;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    pix_ready <= 1'b1;
    wait (lines == 4);
    free = 1'b0;
    repeat (600) begin
      @(posedge ref_clk);
      pix_ready <= 1'($random(seed));
    end
    @(posedge ref_clk);
    pix_ready <= 1'b0;
    // Full buffer must freeze the shift clock rather than drop a word
    repeat (200) @(posedge ref_clk);
    #1;
    chk({14'h0000, pix_valid, horiz_shift_clock_two}, 16'h0003);
    @(posedge ref_clk);
    pix_ready <= 1'b1;
    // Random freezes: no word may be taken twice or skipped
    repeat (400) begin
      @(posedge ref_clk);
      clk_en <= 1'($random(seed)) | 1'($random(seed));
    end
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    #1;
    snap = pins4;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(16'(pins4), 16'(snap));
    // Mid-run reset with the enable back on
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    idx = 0;
    chk(16'({pins4, horiz_shift_clock_two, line_start}), 16'h0002);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(16'({horiz_shift_clock_one, horiz_shift_clock_two}), 16'h0002);
    goal = lines + 2;
    wait (lines >= goal);
    print_verdict;
  end
endmodule // ccdlc_sequencer_tb_top
bind ccdlc_sequencer ccdlc_sequencer_asserts #(.TG_CYC(TG_CYC), .OVR_CYC(OVR_CYC),
  .PIX_CYC(PIX_CYC), .SHIFTS(SHIFTS)) u_chk (.ref_clk, .rst_n, .clk_en, .transfer_gate_pulse,
  .horiz_shift_clock_one, .horiz_shift_clock_two, .reset_gate_pulse, .pix_valid, .pix_ready,
  .pix_index);
